// ===== design/php_consts.svh
// constants for the parallel host port
// assumes inclusion by bare name from design files
`ifndef PHP_CONSTS_SVH
`define PHP_CONSTS_SVH
`define PHP_DATA_W 8
`define PHP_ADDR_W 5
`define PHP_CLK_NS 25
`define PHP_RST_MIN_NS 1000
`define PHP_RST_MIN_CYC ((`PHP_RST_MIN_NS + `PHP_CLK_NS - 1) / `PHP_CLK_NS)
`endif

// ===== design/php_pkg.sv
// types for the parallel host port
// assumes nothing beyond the constants header
package php_pkg;
    typedef enum logic [3:0] {
        PHP_IDLE  = 4'b0001,
        PHP_READ  = 4'b0010,
        PHP_WRITE = 4'b0100,
        PHP_HOLD  = 4'b1000
    } php_state_e;
endpackage : php_pkg

// ===== design/php_strobe_if.sv
// interface between the pin decoder and the access engine
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface php_strobe_if;
    logic rd_act; // read qualifier active
    logic wr_act; // write qualifier active
    modport dec (output rd_act, output wr_act);
    modport eng (input rd_act, input wr_act);
endinterface : php_strobe_if
`default_nettype wire

// ===== design/php_decode.sv
// maps the shared strobe pins to read and write qualifiers
// assumes pins synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module php_decode (
    // pins
    input wire logic i_bus_style_select,
    input wire logic i_cs_n,
    input wire logic i_data_or_read_strobe_n,
    input wire logic i_rw_or_write_strobe_n,
    // qualifiers
    php_strobe_if.dec o_q
);
    // combinational decode per bus style
    always_comb begin
        if (i_cs_n) begin
            o_q.rd_act = 1'b0;
            o_q.wr_act = 1'b0;
        end else if (i_bus_style_select) begin
            o_q.rd_act = ~i_data_or_read_strobe_n;
            o_q.wr_act = ~i_rw_or_write_strobe_n;
        end else begin
            o_q.rd_act = ~i_data_or_read_strobe_n & i_rw_or_write_strobe_n;
            o_q.wr_act = ~i_data_or_read_strobe_n & ~i_rw_or_write_strobe_n;
        end
    end
endmodule : php_decode
`default_nettype wire

// ===== design/php_host_port.sv
// parallel host port: strobe decode, register access handshake, bus drive
// assumes host pins synchronous to i_core_clk; core register file outside
//
// How it works
// - style strap picks separate or data strobe
// - data strobe low performs access
// - read strobe low reads device
// - direction high reads, low writes
// - write strobe low writes device
// - accesses only while chip select low
// - deselected: idle, bus released
// - eight bit data bus, bit0 lsb
// - interrupt open drain, pulls low only
// - interrupt ignores chip select
// - low reset resets, held 1us
// - five address lines, line0 lsb
`timescale 1ns/1ps
`default_nettype none
`include "php_consts.svh"
module php_host_port import php_pkg::*; #(
    parameter int DATA_W = `PHP_DATA_W,
    parameter int ADDR_W = `PHP_ADDR_W
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // host pins
    input wire logic i_bus_style_select,
    input wire logic i_cs_n,
    input wire logic i_data_or_read_strobe_n,
    input wire logic i_rw_or_write_strobe_n,
    input wire logic [ADDR_W-1:0] i_host_addr_lines,
    input wire logic [DATA_W-1:0] i_host_data_bus,
    output logic [DATA_W-1:0] o_host_data_bus,
    output logic o_host_data_oe_n,
    output logic o_irq_n,
    output logic o_irq_oe_n,
    // core side
    input wire logic i_core_irq,
    input wire logic [DATA_W-1:0] i_core_rdata,
    output logic o_core_rd,
    output logic o_core_wr,
    output logic [ADDR_W-1:0] o_core_addr,
    output logic [DATA_W-1:0] o_core_wdata
);
    ////////////////////////////////////////////////////////////////////
    // width check at time zero
    // the pin map is fixed at eight data and five address lines; other
    // widths would leave pins dangling, so such values are reported with $error at time zero
    initial begin
        if (DATA_W != `PHP_DATA_W) begin
            $error("php_host_port: data bus must be eight bits");
        end
        if (ADDR_W != `PHP_ADDR_W) begin
            $error("php_host_port: address must be five lines");
        end
    end

    ////////////////////////////////////////////////////////////////////
    php_strobe_if q (); // decoded qualifiers
    php_state_e state_r; // access state
    php_state_e state_nxt; // next access state
    logic [DATA_W-1:0] rdata_r; // captured read data
    logic take_rd; // read accepted at this edge
    logic take_wr; // write accepted at this edge
    logic take_any; // some access accepted at this edge

    ////////////////////////////////////////////////////////////////////
    // acceptance decode, shared by the capture logic and the checks
    // a strobe is only taken from idle, so a strobe held across many
    // cycles still makes a single core access; read beats write when
    // a careless host lowers both strobes in the separate style
    function automatic logic f_take_rd(input php_state_e st, input logic rd);
        return (st == PHP_IDLE) && rd;
    endfunction : f_take_rd

    // write is taken only when no read competes in the same cycle
    function automatic logic f_take_wr(input php_state_e st, input logic rd, input logic wr);
        return (st == PHP_IDLE) && !rd && wr;
    endfunction : f_take_wr

    // acceptance terms for this cycle
    assign take_rd = f_take_rd(state_r, q.rd_act);
    assign take_wr = f_take_wr(state_r, q.rd_act, q.wr_act);
    assign take_any = take_rd | take_wr;

    // strobe decode
    // qualifiers are already gated by chip select inside the decoder
    php_decode php_decode_inst (
        .i_bus_style_select(i_bus_style_select),
        .i_cs_n(i_cs_n),
        .i_data_or_read_strobe_n(i_data_or_read_strobe_n),
        .i_rw_or_write_strobe_n(i_rw_or_write_strobe_n),
        .o_q(q)
    );

    ////////////////////////////////////////////////////////////////////
    // next state: one core strobe per host strobe
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PHP_IDLE: begin
                if (q.rd_act) begin
                    state_nxt = PHP_READ;
                end else if (q.wr_act) begin
                    state_nxt = PHP_WRITE;
                end
            end
            PHP_READ: state_nxt = PHP_HOLD;
            PHP_WRITE: state_nxt = PHP_HOLD;
            PHP_HOLD: begin
                // wait for strobe release so a long strobe is one access
                if (!q.rd_act && !q.wr_act) begin
                    state_nxt = PHP_IDLE;
                end
            end
            default: state_nxt = PHP_IDLE;
        endcase
    end

    // state register
    // reset parks the engine in idle; the host must keep reset low long
    // enough for the whole device, the port itself needs one edge only
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= PHP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // address and write data capture
    // taken on the first cycle the strobe is seen, so the host must
    // present data together with its strobe; later changes are ignored
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_addr <= '0;
            o_core_wdata <= '0;
        end else if (take_any) begin
            o_core_addr <= i_host_addr_lines;
            o_core_wdata <= i_host_data_bus;
        end
    end

    // core strobes, one cycle each
    // registered from the next state so they line up with the captured
    // address; the core sees address and strobe in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_rd <= 1'b0;
            o_core_wr <= 1'b0;
        end else begin
            o_core_rd <= (state_nxt == PHP_READ);
            o_core_wr <= (state_nxt == PHP_WRITE);
        end
    end

    // read data capture, core answers combinationally to o_core_rd
    // limitation: a core that needs more than one cycle to answer would
    // need a wait state here; none is offered on this port
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
        end else if (state_r == PHP_READ) begin
            rdata_r <= i_core_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus drive: only a selected read, released otherwise
    // the enable follows the pins combinationally so the bus turns
    // around as soon as the host lets go of its strobe; the byte itself
    // is registered and shows the captured word one cycle after take
    assign o_host_data_bus = rdata_r;
    assign o_host_data_oe_n = ~q.rd_act;

    // interrupt: open drain, no chip select term
    // the pin level is fixed low and only its enable moves, so the pin
    // can never be driven high; the board pull-up supplies the high level
    assign o_irq_n = 1'b0;
    assign o_irq_oe_n = ~i_core_irq;

    ////////////////////////////////////////////////////////////////////
    // access start sequences
    sequence s_rd_start;
        state_r == PHP_IDLE && q.rd_act;
    endsequence

    sequence s_wr_start;
        take_wr;
    endsequence

    // a core strobe is exactly one cycle wide
    sequence s_one_pulse_rd;
        o_core_rd ##1 !o_core_rd;
    endsequence

    sequence s_one_pulse_wr;
        o_core_wr ##1 !o_core_wr;
    endsequence

    // a taken read gives one read strobe
    a_read_strobe: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_rd_start |=> s_one_pulse_rd)
        else $error("read strobe wrong");

    // a taken write gives a write strobe
    a_write_strobe: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        state_r == PHP_IDLE && !q.rd_act && q.wr_act |=> o_core_wr)
        else $error("write strobe");

    // nothing reaches the core while deselected
    a_cs_gates: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_cs_n && state_r == PHP_IDLE |=> !o_core_rd && !o_core_wr)
        else $error("access no cs");

    // deselected means the data bus is released
    a_bus_release: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_cs_n |-> o_host_data_oe_n)
        else $error("bus driven while deselected");

    // interrupt enable mirrors the core, pin level always low
    a_irq_follow: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_irq_oe_n == !i_core_irq) && !o_irq_n)
        else $error("irq wrong");

    // data strobe style read drives the bus
    a_ds_read: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_cs_n && !i_bus_style_select && !i_data_or_read_strobe_n && i_rw_or_write_strobe_n
        |-> !o_host_data_oe_n)
        else $error("ds read not driven");

    // data strobe style write never drives the bus
    a_ds_write: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_bus_style_select && !i_rw_or_write_strobe_n |-> o_host_data_oe_n)
        else $error("ds write drove");

    // address captured on the take edge
    a_addr_hold: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_rd_start |=> o_core_addr == $past(i_host_addr_lines))
        else $error("address not captured");

    // separate style read strobe drives the bus
    a_sep_style: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_cs_n && i_bus_style_select && !i_data_or_read_strobe_n |-> !o_host_data_oe_n)
        else $error("separate read not driven");

    ////////////////////////////////////////////////////////////////////
    // further checks on the access engine

    // a write strobe lasts exactly one cycle
    a_write_pulse: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_wr_start |=> s_one_pulse_wr)
        else $error("write strobe not one cycle");

    // write data is the host byte seen at the take edge
    a_wdata_take: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_wr_start |=> o_core_wdata == $past(i_host_data_bus))
        else $error("write data not captured");

    // read data is the core byte seen with the read strobe
    a_rdata_take: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_core_rd |=> o_host_data_bus == $past(i_core_rdata))
        else $error("read data not captured");

    // a strobe held past its access makes no second access
    a_one_access: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        state_r == PHP_HOLD && (q.rd_act || q.wr_act) |=> !o_core_rd && !o_core_wr)
        else $error("held strobe repeated access");

    // read and write strobes never together
    a_strobe_excl: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !(o_core_rd && o_core_wr))
        else $error("read and write strobes together");

    // state code stays one hot
    a_state_onehot: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $onehot(state_r))
        else $error("state code not one hot");

    // bus driven only during a selected read
    a_oe_read_only: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !o_host_data_oe_n |-> !i_cs_n && q.rd_act)
        else $error("bus driven outside a read");

    // interrupt still pulls low while deselected
    a_irq_no_cs: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        i_cs_n && i_core_irq |-> !o_irq_oe_n)
        else $error("irq lost while deselected");
endmodule : php_host_port
`default_nettype wire

// ===== tb/php_host_model.sv
// host processor model for the parallel host port
// assumes the device samples pins on the core clock
`timescale 1ns/1ps
`default_nettype none
module php_host_model (
    // clock and strap
    input wire logic i_clk,
    input wire logic i_style,
    // resolved data bus
    input wire logic [7:0] i_bus,
    // pins toward the device
    output logic o_cs_n,
    output logic o_ds_n,
    output logic o_rw_n,
    output logic [4:0] o_addr,
    output logic [7:0] o_data
);
    // release pins; inverted leftovers so stale values never look valid
    task automatic idle;
        o_cs_n = 1'b1;
        o_ds_n = 1'b1;
        o_rw_n = 1'b1;
        o_addr = ~o_addr;
        o_data = ~o_data;
    endtask : idle

    // quiet bus at time zero
    initial begin
        o_addr = 5'h00;
        o_data = 8'h00;
        idle();
    end

    // one access held three cycles, then a full release
    task automatic access(input logic c_n, input logic w, input logic [4:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge i_clk);
        #2;
        o_cs_n = c_n;
        o_addr = a;
        o_data = w ? d : ~o_data;
        o_ds_n = i_style & w;
        o_rw_n = !w;
        repeat (3) @(posedge i_clk);
        #2;
        q = i_bus;
        idle();
    endtask : access
endmodule : php_host_model
`default_nettype wire

// ===== tb/php_host_port_tb.sv
// self-checking bench for the parallel host port
// assumes a core stub that answers reads with the address xor a pattern
`timescale 1ns/1ps
`default_nettype none
`include "php_consts.svh"
module php_host_port_tb;
    logic clk = 1'b0; // core clock
    logic rst_n = 1'b0; // reset held at start
    logic style = 1'b1; // bus style strap
    logic irq = 1'b0; // core interrupt level
    logic cs_n, ds_n, rw_n, oe_n, irq_n, irq_oe_n, rd, wr;
    logic [4:0] addr, c_addr;
    logic [7:0] hdata, dout, wdata, bus, q;
    int n_fail = 0;
    int checks = 0;
    int n_rd = 0;
    int n_wr = 0;
    int e_rd = 0;
    int e_wr = 0;
    int cyc = 0;

    always #12.5 clk = ~clk; // 40 MHz
    assign bus = oe_n ? hdata : dout; // wire level of the data bus

    php_host_model php_host_model_inst (.i_clk(clk), .i_style(style), .i_bus(bus), .o_cs_n(cs_n),
        .o_ds_n(ds_n), .o_rw_n(rw_n), .o_addr(addr), .o_data(hdata));
    php_host_port php_host_port_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_bus_style_select(style),
        .i_cs_n(cs_n), .i_data_or_read_strobe_n(ds_n), .i_rw_or_write_strobe_n(rw_n),
        .i_host_addr_lines(addr), .i_host_data_bus(hdata), .o_host_data_bus(dout),
        .o_host_data_oe_n(oe_n), .o_irq_n(irq_n), .o_irq_oe_n(irq_oe_n), .i_core_irq(irq),
        .i_core_rdata({3'h0, c_addr} ^ 8'h5a), .o_core_rd(rd), .o_core_wr(wr),
        .o_core_addr(c_addr), .o_core_wdata(wdata));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : close_out

    // count core strobes and cut a hang short
    always @(posedge clk) begin
        n_rd <= n_rd + int'(rd === 1'b1);
        n_wr <= n_wr + int'(wr === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 400) begin
            n_fail++;
            close_out();
        end
    end

    // bus driven only by a selected read, mid cycle when pins are settled
    always @(negedge clk) chk(oe_n, !(!cs_n && !ds_n && (style || rw_n)));

    // write top address then read address one; a held strobe gives one access
    task automatic run_style(input logic s);
        style = s;
        php_host_model_inst.access(1'b0, 1'b1, 5'h1f, 8'h80, q);
        e_wr++;
        chk(wdata, 8'h80);
        chk({3'h0, c_addr}, 8'h1f);
        php_host_model_inst.access(1'b0, 1'b0, 5'h01, 8'h00, q);
        e_rd++;
        chk(q, 8'h5b);
        chk(n_wr, e_wr);
        chk(n_rd, e_rd);
    endtask : run_style

    // strobes with chip select high reach nothing
    task automatic run_desel;
        for (int k = 0; k < 2; k++) begin
            php_host_model_inst.access(1'b1, k[0], 5'h0a, 8'h33, q);
            chk(n_rd, e_rd);
            chk(n_wr, e_wr);
        end
    endtask : run_desel

    // interrupt follows the core while deselected, never driven high
    task automatic run_irq;
        for (int k = 1; k >= 0; k--) begin
            @(posedge clk);
            #2;
            irq = k[0];
            @(negedge clk);
            chk(irq_oe_n, !k[0]);
            chk(irq_n, 1'b0);
        end
    endtask : run_irq

    // reset again in mid run, then a clean write and read
    task automatic run_reset;
        @(posedge clk);
        #2;
        rst_n = 1'b0;
        repeat (`PHP_RST_MIN_CYC) @(posedge clk);
        #2;
        chk(dout, 8'h00);
        chk({3'h0, c_addr}, 8'h00);
        chk(wdata, 8'h00);
        rst_n = 1'b1;
        run_style(1'b0);
    endtask : run_reset

    // reset for PHP_RST_MIN_CYC edges, just under the minimum time, then the scenarios
    initial begin
        repeat (`PHP_RST_MIN_CYC) @(posedge clk);
        #2;
        chk(dout, 8'h00);
        rst_n = 1'b1;
        run_style(1'b1);
        run_style(1'b0);
        run_desel();
        run_irq();
        run_reset();
        close_out();
    end
endmodule : php_host_port_tb
`default_nettype wire
